// >>> inc/interrupt_controller_unit_pkg.sv
package interrupt_controller_unit_pkg;

    localparam int SRC_LARGE = 44;
    localparam int SRC_SMALL = 41;
    localparam int IDX_W     = 6;
    localparam int LVL_W     = 3;
    localparam int PIN_COUNT = 7;
    localparam int PIN_BASE  = 1;
    localparam int WDT_SRC   = 0;
    localparam int HIST_LEN  = 3;
    localparam int OP_W      = 5;
    localparam int OP_GRP    = 4;

    localparam logic [LVL_W-1:0] LEVEL_RESET  = 3'h7;
    localparam logic [3:0]       SERVICE_NONE = 4'h8;

    localparam logic [15:0] CODE_RESET    = 16'h0000;
    localparam logic [15:0] CODE_NMI_PIN  = 16'h0010;
    localparam logic [15:0] CODE_NMI_WDT  = 16'h0020;
    localparam logic [15:0] CODE_TRAP_LOW = 16'h0040;
    localparam logic [15:0] CODE_TRAP_HI  = 16'h0050;
    localparam logic [15:0] CODE_ILLEGAL  = 16'h0060;
    localparam logic [15:0] CODE_MASK_BASE = 16'h0080;
    localparam int          CODE_STEP_SH  = 4;

    localparam logic [1:0] EDGE_NONE    = 2'h0;
    localparam logic [1:0] EDGE_RISING  = 2'h1;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_ILLEGAL,
        KIND_TRAP,
        KIND_NMI_PIN,
        KIND_NMI_WDT,
        KIND_MASKABLE
    } kind_t;

    typedef enum logic {
        ST_IDLE,
        ST_PRESENT
    } state_t;

    typedef struct packed {
        logic [15:0] code;
        logic [31:0] handler;
        logic [31:0] return_pc;
    } exc_resp_t;

endpackage : interrupt_controller_unit_pkg

// >>> hdl/priority_level_store.sv
`timescale 1ns/1ps
module priority_level_store
    import interrupt_controller_unit_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic                          wr_en,
    input  wire logic [IDX_W-1:0]              wr_idx,
    input  wire logic [LVL_W-1:0]              wr_level,
    output logic      [SRC_LARGE*LVL_W-1:0]    levels
);

    logic [LVL_W-1:0] mem_q [SRC_LARGE];

    // Every entry is a flop so the arbiter can see all levels at once
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < SRC_LARGE; i++) begin
                mem_q[i] <= LEVEL_RESET;
            end
        end else if (wr_en && (int'(wr_idx) < SRC_LARGE)) begin
            mem_q[wr_idx] <= wr_level;
        end
    end

    for (genvar g = 0; g < SRC_LARGE; g++) begin : g_out
        assign levels[g*LVL_W +: LVL_W] = mem_q[g];
    end

endmodule : priority_level_store

// >>> hdl/interrupt_controller_unit.sv
`timescale 1ns/1ps
// Function
// - 41 or 44 maskable sources per build
// - Two non-maskable sources: pin and watchdog
// - Eight programmable levels steer arbitration
// - Levels not above servicing level held off
// - Per-source mask blocks forwarding
// - Pin noise filter with selectable valid edge
// - 32 trap operands raise software exceptions
// - Illegal opcode trap ignores masking state
// - Trap codes 004n/005n, handlers 40/50
// - Fixed codes; maskable from 0080 step 10
// - Same level: lowest default number wins
// - Non-maskable beats maskable, ignores disable
module interrupt_controller_unit
    import interrupt_controller_unit_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
)
(
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic [PIN_COUNT-1:0]     pin_in,
    input  wire logic [2*PIN_COUNT-1:0]   edge_select,
    input  wire logic                     nmi_pin,
    input  wire logic [1:0]               nmi_edge_select,
    input  wire logic                     watchdog_overflow,
    input  wire logic                     wdt_nonmaskable_mode,
    input  wire logic [SRC_LARGE-1:0]     periph_req,
    input  wire logic [SRC_LARGE-1:0]     source_mask,
    input  wire logic                     lvl_wr_en,
    input  wire logic [IDX_W-1:0]         lvl_wr_idx,
    input  wire logic [LVL_W-1:0]         lvl_wr_level,
    input  wire logic [3:0]               servicing_level,
    input  wire logic                     interrupts_disabled_state,
    input  wire logic                     trap_valid,
    input  wire logic [OP_W-1:0]          trap_operand,
    input  wire logic                     illegal_opcode_exception,
    input  wire logic [31:0]              next_pc,
    input  wire logic                     core_ack,
    output logic                          exc_valid,
    output exc_resp_t                     exc_resp,
    output logic [SRC_LARGE-1:0]          pending,
    output logic                          nmi_pending
);

    localparam int SRC_COUNT = LARGE_VARIANT ? SRC_LARGE : SRC_SMALL;
    ////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic       now_lvl,
                                      input logic       old_lvl);
        case (sel)
            EDGE_RISING:  edge_hit = now_lvl & ~old_lvl;
            EDGE_FALLING: edge_hit = ~now_lvl & old_lvl;
            EDGE_BOTH:    edge_hit = now_lvl ^ old_lvl;
            default:      edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // Lowest level first, then lowest index; scanning downward with <=
    // lets the lower index overwrite an equal-level winner.
    function automatic logic [IDX_W:0] pick(
        input logic [SRC_LARGE-1:0]       elig,
        input logic [SRC_LARGE*LVL_W-1:0] lv);
        logic [LVL_W-1:0] best;
        logic             found;
        logic [IDX_W-1:0] idx;
        best  = LEVEL_RESET;
        found = 1'b0;
        idx   = '0;
        for (int i = SRC_LARGE - 1; i >= 0; i--) begin
            if (elig[i] && (!found || lv[i*LVL_W +: LVL_W] <= best)) begin
                best  = lv[i*LVL_W +: LVL_W];
                found = 1'b1;
                idx   = IDX_W'(i);
            end
        end
        pick = {found, idx};
    endfunction : pick

    ////////////////////////////////////////////////////////////////////////
    // External pin filtering and edge detection
    logic [PIN_COUNT:0]   sync1_q;
    logic [PIN_COUNT:0]   sync2_q;
    logic [HIST_LEN-1:0]  hist_q [PIN_COUNT+1];
    logic [PIN_COUNT:0]   filt_q;
    logic [PIN_COUNT:0]   filt_old_q;
    logic [PIN_COUNT:0]   pin_event;
    logic [2*PIN_COUNT+1:0] all_sel;

    assign all_sel = {nmi_edge_select, edge_select};

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {nmi_pin, pin_in};
            sync2_q <= sync1_q;
        end
    end

    // A level counts only after it has held for HIST_LEN samples
    for (genvar p = 0; p <= PIN_COUNT; p++) begin : g_pin
        always_ff @(posedge clk) begin
            if (srst) begin
                hist_q[p]     <= '0;
                filt_q[p]     <= 1'b0;
                filt_old_q[p] <= 1'b0;
            end else begin
                hist_q[p] <= {hist_q[p][HIST_LEN-2:0], sync2_q[p]};
                if (&hist_q[p]) begin
                    filt_q[p] <= 1'b1;
                end else if (~|hist_q[p]) begin
                    filt_q[p] <= 1'b0;
                end
                filt_old_q[p] <= filt_q[p];
            end
        end
        assign pin_event[p] = edge_hit(all_sel[2*p +: 2], filt_q[p],
                                       filt_old_q[p]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Request collection
    logic [SRC_LARGE-1:0] set_vec;
    logic [SRC_LARGE-1:0] present;
    logic [SRC_LARGE-1:0] pend_q;
    logic [SRC_LARGE*LVL_W-1:0] levels;
    logic [SRC_LARGE-1:0] elig;
    logic                 nmi_pin_set;
    logic                 nmi_wdt_set;
    logic                 nmi_pin_q;
    logic                 nmi_wdt_q;
    logic                 nmi_pin_d;
    logic                 nmi_wdt_d;
    logic                 nmi_pend_q;
    logic                 trap_q;
    logic [OP_W-1:0]      trap_op_q;
    logic                 ilg_q;

    for (genvar i = 0; i < SRC_LARGE; i++) begin : g_src
        assign present[i] = (i < SRC_COUNT);
        if (i == WDT_SRC) begin : g_wdt
            assign set_vec[i] = watchdog_overflow & ~wdt_nonmaskable_mode;
        end else if (i >= PIN_BASE && i < PIN_BASE + PIN_COUNT) begin : g_p
            assign set_vec[i] = pin_event[i-PIN_BASE];
        end else begin : g_per
            assign set_vec[i] = periph_req[i] & present[i];
        end
        assign elig[i] = pend_q[i] & ~source_mask[i]
                       & ({1'b0, levels[i*LVL_W +: LVL_W]}
                          < servicing_level)
                       & ~interrupts_disabled_state;
    end
    assign nmi_pin_set = pin_event[PIN_COUNT];
    assign nmi_wdt_set = watchdog_overflow & wdt_nonmaskable_mode;

    priority_level_store u_levels (
        .clk      (clk),
        .srst     (srst),
        .wr_en    (lvl_wr_en),
        .wr_idx   (lvl_wr_idx),
        .wr_level (lvl_wr_level),
        .levels   (levels)
    );

    ////////////////////////////////////////////////////////////////////////
    // Selection
    state_t           state_q;
    kind_t            kind_q;
    logic [IDX_W-1:0] idx_q;
    exc_resp_t        resp_q;
    kind_t            win_kind;
    logic [IDX_W:0]   win;
    exc_resp_t        win_resp;
    logic             done;

    assign win = pick(elig, levels);
    // Synchronous exceptions first, then non-maskable, then maskable
    assign win_kind = ilg_q       ? KIND_ILLEGAL :
                      trap_q      ? KIND_TRAP :
                      nmi_pin_q   ? KIND_NMI_PIN :
                      nmi_wdt_q   ? KIND_NMI_WDT :
                      win[IDX_W]  ? KIND_MASKABLE : KIND_NONE;

    always_comb begin
        win_resp.return_pc = next_pc;
        case (win_kind)
            KIND_ILLEGAL: win_resp.code = CODE_ILLEGAL;
            KIND_TRAP: begin
                win_resp.code = (trap_op_q[OP_GRP] ? CODE_TRAP_HI
                                 : CODE_TRAP_LOW)
                              | {12'h000, trap_op_q[OP_GRP-1:0]};
            end
            KIND_NMI_PIN: win_resp.code = CODE_NMI_PIN;
            KIND_NMI_WDT: win_resp.code = CODE_NMI_WDT;
            KIND_MASKABLE: begin
                win_resp.code = CODE_MASK_BASE
                    + (16'(win[IDX_W-1:0]) << CODE_STEP_SH);
            end
            default: win_resp.code = CODE_RESET;
        endcase
        // Both trap groups share one handler per group
        if (win_kind == KIND_TRAP) begin
            win_resp.handler = {16'h0000, win_resp.code & 16'hFFF0};
        end else begin
            win_resp.handler = {16'h0000, win_resp.code};
        end
    end

    assign done = (state_q == ST_PRESENT) && core_ack;

    ////////////////////////////////////////////////////////////////////////
    // Pending flags; a new event in the clearing cycle survives
    assign nmi_pin_d = nmi_pin_set
                     | (nmi_pin_q & ~(done && kind_q == KIND_NMI_PIN));
    assign nmi_wdt_d = nmi_wdt_set
                     | (nmi_wdt_q & ~(done && kind_q == KIND_NMI_WDT));
    always_ff @(posedge clk) begin
        if (srst) begin
            pend_q    <= '0;
            nmi_pend_q <= 1'b0;
            nmi_pin_q <= 1'b0;
            nmi_wdt_q <= 1'b0;
            trap_q    <= 1'b0;
            trap_op_q <= '0;
            ilg_q     <= 1'b0;
        end else begin
            for (int i = 0; i < SRC_LARGE; i++) begin
                if (set_vec[i]) begin
                    pend_q[i] <= 1'b1;
                end else if (done && kind_q == KIND_MASKABLE
                             && int'(idx_q) == i) begin
                    pend_q[i] <= 1'b0;
                end
            end
            nmi_pin_q  <= nmi_pin_d;
            nmi_wdt_q  <= nmi_wdt_d;
            nmi_pend_q <= nmi_pin_d | nmi_wdt_d;
            ilg_q     <= illegal_opcode_exception
                       | (ilg_q & ~(done && kind_q == KIND_ILLEGAL));
            if (trap_valid) begin
                trap_q    <= 1'b1;
                trap_op_q <= trap_operand;
            end else if (done && kind_q == KIND_TRAP) begin
                trap_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Presentation to the core; a waiting request is never preempted
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            kind_q  <= KIND_NONE;
            idx_q   <= '0;
            resp_q  <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (win_kind != KIND_NONE) begin
                        state_q <= ST_PRESENT;
                        kind_q  <= win_kind;
                        idx_q   <= win[IDX_W-1:0];
                        resp_q  <= win_resp;
                    end
                end
                ST_PRESENT: begin
                    if (core_ack) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    assign exc_valid   = (state_q == ST_PRESENT);
    assign exc_resp    = resp_q;
    assign pending     = pend_q;
    assign nmi_pending = nmi_pend_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_src_count_limit:
    assert property (@(posedge clk) disable iff (srst)
        (pend_q & ~present) == '0)
    else $error("pending flag set on an absent source");
    a_nmi_before_mask:
    assert property (@(posedge clk) disable iff (srst)
        (state_q == ST_IDLE && (nmi_pin_q || nmi_wdt_q) && !ilg_q
         && !trap_q) |=> kind_q inside {KIND_NMI_PIN, KIND_NMI_WDT})
    else $error("maskable request beat a non-maskable one");
    a_mask_blocks_src:
    assert property (@(posedge clk) disable iff (srst)
        (state_q == ST_IDLE && win_kind == KIND_MASKABLE)
        |-> !source_mask[win[IDX_W-1:0]])
    else $error("masked source was selected");
    a_level_holdoff:
    assert property (@(posedge clk) disable iff (srst)
        (state_q == ST_IDLE && win_kind == KIND_MASKABLE)
        |-> ({1'b0, levels[win[IDX_W-1:0]*LVL_W +: LVL_W]}
             < servicing_level) && !interrupts_disabled_state)
    else $error("maskable request passed a level hold-off");
    a_trap_code_map:
    assert property (@(posedge clk) disable iff (srst)
        (state_q == ST_IDLE && win_kind == KIND_TRAP) |=>
        exc_resp.code == {4'h0, ($past(trap_op_q[OP_GRP]) ? 8'h05 : 8'h04),
                          $past(trap_op_q[OP_GRP-1:0])}
        && exc_resp.handler == {16'h0000, exc_resp.code[15:4], 4'h0})
    else $error("trap code or handler wrong");
    a_maskable_code:
    assert property (@(posedge clk) disable iff (srst)
        (state_q == ST_IDLE && win_kind == KIND_MASKABLE) |=>
        exc_resp.code == 16'h0080 + {6'h00, idx_q, 4'h0}
        && exc_resp.handler == {16'h0000, exc_resp.code})
    else $error("maskable code does not match its index");
    a_return_addr:
    assert property (@(posedge clk) disable iff (srst)
        (state_q == ST_IDLE && win_kind != KIND_NONE) |=>
        exc_resp.return_pc == $past(next_pc))
    else $error("return address not the next instruction");
    a_illegal_opcode_exception_first:
    assert property (@(posedge clk) disable iff (srst)
        (state_q == ST_IDLE && ilg_q) |=> kind_q == KIND_ILLEGAL
        ##0 exc_resp.code == 16'h0060)
    else $error("illegal opcode trap not taken first");
    a_hold_until_ack:
    assert property (@(posedge clk) disable iff (srst)
        (exc_valid && !core_ack) |=> exc_valid && $stable(exc_resp))
    else $error("presented request changed before acknowledge");

endmodule : interrupt_controller_unit

// >>> tb/core_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Core side: accepts a presented request after ack_delay waiting cycles
module core_model
    import interrupt_controller_unit_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       exc_valid,
    input  wire exc_resp_t  exc_resp,
    input  wire logic [2:0] ack_delay,
    output logic            core_ack,
    output logic            taken,
    output exc_resp_t       taken_resp
);
    logic [2:0] wait_q;

    // Ack stands one edge only, so a held request is never taken twice
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_q   <= 3'h0;
            core_ack <= 1'b0;
            taken    <= 1'b0;
        end else begin
            taken    <= core_ack & exc_valid;
            core_ack <= 1'b0;
            if (core_ack & exc_valid) begin
                taken_resp <= exc_resp;
            end else if (exc_valid && wait_q >= ack_delay) begin
                core_ack <= 1'b1;
                wait_q   <= 3'h0;
            end else if (exc_valid) begin
                wait_q <= wait_q + 3'h1;
            end
        end
    end
endmodule : core_model

// >>> tb/interrupt_exception_controller_test.sv
`timescale 1ns/1ps
module interrupt_exception_controller_test
    import interrupt_controller_unit_pkg::*;
();
    logic                   clk, srst, nmi_pin, watchdog_overflow;
    logic [PIN_COUNT-1:0]   pin_in;
    logic [2*PIN_COUNT-1:0] edge_select;
    logic [1:0]             nmi_edge_select, e;
    logic                   wdt_nonmaskable_mode, lvl_wr_en;
    logic [SRC_LARGE-1:0]   periph_req, source_mask, pending;
    logic [IDX_W-1:0]       lvl_wr_idx;
    logic [LVL_W-1:0]       lvl_wr_level;
    logic [3:0]             servicing_level;
    logic                   interrupts_disabled_state, trap_valid;
    logic [OP_W-1:0]        trap_operand;
    logic                   illegal_opcode_exception, core_ack;
    logic [31:0]            next_pc;
    logic                   exc_valid, nmi_pending, taken;
    exc_resp_t              exc_resp, taken_resp;
    logic [2:0]             ack_delay;
    int                     n_fail, tests_run, seed, idx;

    interrupt_controller_unit dut_u (
        .clk, .srst, .pin_in, .edge_select, .nmi_pin, .nmi_edge_select,
        .watchdog_overflow, .wdt_nonmaskable_mode, .periph_req,
        .source_mask, .lvl_wr_en, .lvl_wr_idx, .lvl_wr_level,
        .servicing_level, .interrupts_disabled_state, .trap_valid,
        .trap_operand, .illegal_opcode_exception, .next_pc, .core_ack,
        .exc_valid, .exc_resp, .pending, .nmi_pending
    );

    core_model core_u (
        .clk, .srst, .exc_valid, .exc_resp, .ack_delay, .core_ack,
        .taken, .taken_resp
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [15:0] mcode(input int i);
        return CODE_MASK_BASE + 16'(i << CODE_STEP_SH);
    endfunction : mcode

    // Both trap groups share one handler each; all others jump to code
    function automatic logic [31:0] hnd(input logic [15:0] code);
        if (code[15:5] == 11'h002) begin
            return code[4] ? 32'h00000050 : 32'h00000040;
        end
        return {16'h0000, code};
    endfunction : hnd

    // Pulses last one cycle: every strobe drops at the next falling edge
    task automatic tick();
        @(negedge clk);
        periph_req = '0;
        trap_valid = 1'b0;
        illegal_opcode_exception = 1'b0;
        watchdog_overflow = 1'b0;
        lvl_wr_en = 1'b0;
    endtask : tick

    task automatic set_level(input int i, input logic [2:0] lv);
        lvl_wr_en = 1'b1;
        lvl_wr_idx = 6'(i);
        lvl_wr_level = lv;
        tick();
    endtask : set_level

    task automatic expect_code(input logic [15:0] code);
        int i;
        i = 0;
        while (taken !== 1'b1 && i < 80) begin
            @(negedge clk);
            i++;
        end
        if (i >= 80) begin
            n_fail++;
            $display("BAD wait expected %h seen none", code);
            wrap_up();
        end
        check("code", {16'h0, code}, {16'h0, taken_resp.code});
        check("handler", hnd(code), taken_resp.handler);
        check("return_pc", next_pc, taken_resp.return_pc);
        @(negedge clk);
    endtask : expect_code

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge clk);
            if (exc_valid !== 1'b0) seen = 1'b1;
        end
        check("quiet", 32'h0, {31'h0, seen});
    endtask : quiet

    ////////////////////////////////////////////////////////////////////
    initial begin
        seed = 46;
        n_fail = 0;
        tests_run = 0;
        srst = 1'b1;
        {pin_in, edge_select, nmi_pin, nmi_edge_select} = '0;
        {watchdog_overflow, wdt_nonmaskable_mode, lvl_wr_en} = '0;
        {periph_req, source_mask, lvl_wr_idx, lvl_wr_level} = '0;
        {interrupts_disabled_state, trap_valid, trap_operand} = '0;
        illegal_opcode_exception = 1'b0;
        servicing_level = SERVICE_NONE;
        next_pc = 32'h00001000;
        ack_delay = 3'h0;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        check("exc_valid", 32'h0, {31'h0, exc_valid});
        check("pending", 32'h0, {31'h0, |pending});
        check("nmi_pending", 32'h0, {31'h0, nmi_pending});
        for (int op = 0; op < 32; op++) begin
            ack_delay = 3'($unsigned($random(seed)) % 5);
            trap_operand = 5'(op);
            trap_valid = 1'b1;
            tick();
            expect_code((op < 16 ? 16'h0040 : 16'h0050) | 16'(op % 16));
        end
        watchdog_overflow = 1'b1;
        tick();
        expect_code(mcode(WDT_SRC));
        repeat (16) begin
            idx = 8 + int'($unsigned($random(seed)) % 36);
            next_pc = $random(seed);
            ack_delay = 3'($unsigned($random(seed)) % 5);
            periph_req[idx] = 1'b1;
            tick();
            expect_code(mcode(idx));
        end
        // Glitch of two cycles must never reach the filtered level
        edge_select[1:0] = EDGE_RISING;
        pin_in[0] = 1'b1;
        tick();
        tick();
        pin_in[0] = 1'b0;
        quiet(12);
        for (int p = 0; p < PIN_COUNT; p++) begin
            e = 2'(1 + p % 3);
            edge_select[2*p +: 2] = e;
            pin_in[p] = 1'b1;
            if (e == EDGE_FALLING) begin
                quiet(12);
                pin_in[p] = 1'b0;
            end
            expect_code(mcode(p + PIN_BASE));
            pin_in[p] = 1'b0;
            if (e == EDGE_BOTH) expect_code(mcode(p + PIN_BASE));
            else quiet(12);
        end
        // With no valid edge chosen, neither edge may raise a request
        edge_select[1:0] = EDGE_NONE;
        pin_in[0] = 1'b1;
        quiet(12);
        pin_in[0] = 1'b0;
        quiet(12);
        interrupts_disabled_state = 1'b1;
        wdt_nonmaskable_mode = 1'b1;
        periph_req[12] = 1'b1;
        watchdog_overflow = 1'b1;
        trap_valid = 1'b1;
        trap_operand = 5'h13;
        illegal_opcode_exception = 1'b1;
        tick();
        check("nmi_pending", 32'h1, {31'h0, nmi_pending});
        expect_code(CODE_ILLEGAL);
        expect_code(16'h0053);
        expect_code(CODE_NMI_WDT);
        quiet(8);
        check("nmi_pending", 32'h0, {31'h0, nmi_pending});
        nmi_edge_select = EDGE_RISING;
        nmi_pin = 1'b1;
        expect_code(CODE_NMI_PIN);
        nmi_pin = 1'b0;
        interrupts_disabled_state = 1'b0;
        expect_code(mcode(12));
        source_mask[15] = 1'b1;
        periph_req[15] = 1'b1;
        tick();
        quiet(8);
        check("pending", 32'h1, {31'h0, pending[15]});
        source_mask[15] = 1'b0;
        expect_code(mcode(15));
        set_level(30, 3'h5);
        servicing_level = 4'h5;
        periph_req[30] = 1'b1;
        tick();
        quiet(8);
        check("pending", 32'h1, {31'h0, pending[30]});
        servicing_level = 4'h6;
        expect_code(mcode(30));
        servicing_level = SERVICE_NONE;
        set_level(20, 3'h2);
        set_level(10, 3'h3);
        periph_req[10] = 1'b1;
        periph_req[20] = 1'b1;
        tick();
        expect_code(mcode(20));
        expect_code(mcode(10));
        set_level(20, 3'h3);
        periph_req[10] = 1'b1;
        periph_req[20] = 1'b1;
        periph_req[8] = 1'b1;
        periph_req[43] = 1'b1;
        tick();
        expect_code(mcode(10));
        expect_code(mcode(20));
        expect_code(mcode(8));
        expect_code(mcode(43));
        wrap_up();
    end
endmodule : interrupt_exception_controller_test
